// ==== design/adcc_pkg.sv ====
// Purpose: constants for the converter control register block
// Assumes: classic wishbone, 32-bit data, byte-wide registers in the low bits
// Notes: offsets are byte addresses of aligned words
package adcc_pkg;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h00;
  localparam logic [7:0] OFS_RESULT_LOW = 8'h04;
  localparam logic [7:0] OFS_CONTROL_MAIN = 8'h08;
  localparam logic [7:0] OFS_CONTROL_SELECT = 8'h0C;
  localparam logic [7:0] OFS_PIN_ENABLE = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  // conv_control_main fields
  localparam int BIT_START = 7;
  localparam int BIT_BUSY = 6;
  localparam int BIT_POWER = 5;
  localparam int BIT_ALIGN = 4;
  // conv_control_select fields
  localparam int POS_SRC = 5;
  localparam int POS_REF = 3;
  localparam int POS_DIV = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int RESULT_W = 12;
  localparam int NUM_CH = 8;
  localparam logic [3:0] CH_LAST = 4'h7;
  localparam logic [2:0] SRC_BANDGAP = 3'h1;
  localparam logic [2:0] SRC_GND_LO = 3'h2;
  localparam logic [2:0] SRC_GND_HI = 3'h4;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam int IRQ_DONE = 0;
  typedef enum logic [1:0] {
    ADCC_SRC_EXT = 2'b00,
    ADCC_SRC_BG = 2'b01,
    ADCC_SRC_GND = 2'b10
  } adcc_src_e;
endpackage

// ==== design/adcc_top.sv ====
// Purpose: register and control logic for one 12-bit converter
// Assumes: analog core gives a one-cycle done pulse with its result
// Notes: wishbone slave answers every access in one wait-free cycle
module adcc_top
  import adcc_pkg::*;
(
  input wire logic mclk_i, // system clock
  input wire logic srst_i, // synchronous reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  output logic wb_err_o, // unmapped access
  output logic irq_o, // interrupt level
  output logic conv_start_o, // pulse to core
  output logic conv_power_o, // core power enable
  output logic [NUM_CH-1:0] ext_channel_route_o, // one-hot mux, none if floating
  output logic [1:0] source_route_o, // adcc_src_e code
  output logic ref_from_supply_o, // reference is internal supply
  output logic conv_clk_en_o, // divided conversion clock tick
  output logic [NUM_CH-1:0] analog_pin_bits_o, // pins in analog mode
  output logic [NUM_CH-1:0] pull_high_allow_o, // pull-high permitted
  input wire logic conv_done_i, // core done pulse
  input wire logic [RESULT_W-1:0] conv_data_i // core result
);

  // ---------------------------------------------------------------
  // decoding
  // ---------------------------------------------------------------
  function automatic adcc_src_e src_decode(input logic [2:0] code);
    if (code == SRC_BANDGAP) begin
      return ADCC_SRC_BG;
    end else if (code >= SRC_GND_LO && code <= SRC_GND_HI) begin
      return ADCC_SRC_GND;
    end
    return ADCC_SRC_EXT;
  endfunction

  // one list of mapped offsets keeps ack and err exclusive
  function automatic logic reg_mapped(input logic [7:0] adr);
    logic m;
    m = 1'b0;
    case (adr)
      OFS_RESULT_HIGH, OFS_RESULT_LOW, OFS_CONTROL_MAIN, OFS_CONTROL_SELECT,
      OFS_PIN_ENABLE, OFS_IRQ_STATUS, OFS_IRQ_MASK: begin
        m = 1'b1;
      end
      default: begin
        m = 1'b0;
      end
    endcase
    return m;
  endfunction

  logic [7:0] ctl_q; // start, -, power, align, channel
  logic [7:0] sel_q;
  logic [7:0] pin_q;
  logic busy_q;
  logic [RESULT_W-1:0] result_q;
  logic [0:0] irq_stat_q;
  logic [0:0] irq_mask_q;
  logic [6:0] div_q;
  logic ack_q;

  logic acc;
  logic wr;
  logic hit;
  logic start_fall;
  logic done_ev;
  // err blocks a repeat, so it pulses once just like ack
  assign acc = wb_cyc_i & wb_stb_i & ~ack_q & ~wb_err_o;
  // writes land on the request edge, the same edge that raises ack
  assign wr = acc & wb_we_i & wb_sel_i[0];
  assign hit = reg_mapped(wb_adr_i);
  // write that takes start from high to low
  assign start_fall = wr && wb_adr_i == OFS_CONTROL_MAIN && ctl_q[BIT_START] &&
                      !wb_dat_i[BIT_START];
  assign done_ev = busy_q & conv_done_i;

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ack_q <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      ack_q <= acc & hit;
      wb_err_o <= acc & ~hit;
    end
  end
  assign wb_ack_o = ack_q;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ctl_q <= RESET_BYTE;
      sel_q <= RESET_BYTE;
      pin_q <= RESET_BYTE;
      irq_mask_q <= 1'b0;
    end else if (wr) begin
      unique case (wb_adr_i)
        OFS_CONTROL_MAIN: begin
          // busy position is never stored
          ctl_q <= {wb_dat_i[7], 1'b0, wb_dat_i[5:0]};
        end
        OFS_CONTROL_SELECT: begin
          sel_q <= wb_dat_i[7:0];
        end
        OFS_PIN_ENABLE: begin
          pin_q <= wb_dat_i[7:0];
        end
        OFS_IRQ_MASK: begin
          irq_mask_q <= wb_dat_i[0:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // conversion sequencing
  // ---------------------------------------------------------------
  // start wins over a done in the same cycle, so no restart is lost
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      busy_q <= 1'b0;
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= start_fall;
      if (start_fall) begin
        busy_q <= 1'b1;
      end else if (conv_done_i) begin
        busy_q <= 1'b0;
      end
    end
  end

  // result kept through power-down; loads only on completion
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      result_q <= '0;
    end else if (done_ev) begin
      result_q <= conv_data_i;
    end
  end

  // ---------------------------------------------------------------
  // interrupt: set wins over write-one clear
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      irq_stat_q <= 1'b0;
    end else if (done_ev) begin
      irq_stat_q[IRQ_DONE] <= 1'b1;
    end else if (wr && wb_adr_i == OFS_IRQ_STATUS && wb_dat_i[IRQ_DONE]) begin
      irq_stat_q[IRQ_DONE] <= 1'b0;
    end
  end
  assign irq_o = |(irq_stat_q & irq_mask_q);

  // ---------------------------------------------------------------
  // conversion clock divider
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i || !ctl_q[BIT_POWER]) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 7'd1;
    end
  end
  logic [7:0] div_mask;
  assign div_mask = (8'h01 << sel_q[POS_DIV +: 3]) - 8'h01;
  // tick every 2^code system clocks
  assign conv_clk_en_o = ctl_q[BIT_POWER] && ((div_q & div_mask[6:0]) == 7'h00);

  // ---------------------------------------------------------------
  // analog routing
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_route
      // codes 8..15 match nothing, input floats
      assign ext_channel_route_o[g] = (ctl_q[3:0] == 4'(g)) &&
                                      (ctl_q[3:0] <= CH_LAST);
      assign pull_high_allow_o[g] = ~pin_q[g];
    end
  endgenerate
  assign analog_pin_bits_o = pin_q;
  assign source_route_o = src_decode(sel_q[POS_SRC +: 3]);
  assign ref_from_supply_o = (sel_q[POS_REF +: 2] == REF_SUPPLY);
  assign conv_power_o = ctl_q[BIT_POWER];

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [7:0] res_hi;
  logic [7:0] res_lo;
  always_comb begin
    if (ctl_q[BIT_ALIGN]) begin
      res_hi = {4'h0, result_q[11:8]};
      res_lo = result_q[7:0];
    end else begin
      res_hi = result_q[11:4];
      res_lo = {result_q[3:0], 4'h0};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (acc && !wb_we_i) begin
      unique case (wb_adr_i)
        OFS_RESULT_HIGH: wb_dat_o <= {24'h00_0000, res_hi};
        OFS_RESULT_LOW: wb_dat_o <= {24'h00_0000, res_lo};
        OFS_CONTROL_MAIN: wb_dat_o <= {24'h00_0000, ctl_q[7], busy_q, ctl_q[5:0]};
        OFS_CONTROL_SELECT: wb_dat_o <= {24'h00_0000, sel_q};
        OFS_PIN_ENABLE: wb_dat_o <= {24'h00_0000, pin_q};
        OFS_IRQ_STATUS: wb_dat_o <= {31'h0000_0000, irq_stat_q};
        OFS_IRQ_MASK: wb_dat_o <= {31'h0000_0000, irq_mask_q};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_start_seq;
    start_fall;
  endsequence

  a_busy_sets: assert property (s_start_seq |=> busy_q)
    else $error("busy not set after start");
  a_start_pulse: assert property (s_start_seq |=> conv_start_o ##1 !conv_start_o)
    else $error("start pulse wrong");
  a_busy_clears: assert property (busy_q && conv_done_i && !start_fall |=> !busy_q)
    else $error("busy not cleared");
  a_result_load: assert property (done_ev |=> result_q == $past(conv_data_i))
    else $error("result not loaded");
  a_result_hold: assert property (!done_ev |=> $stable(result_q))
    else $error("result changed without done");
  a_irq_sets: assert property (done_ev |=> irq_stat_q[IRQ_DONE])
    else $error("interrupt flag not set");
  a_hi_zero: assert property (ctl_q[BIT_ALIGN] |-> res_hi[7:4] == 4'h0)
    else $error("unused high bits nonzero");
  a_lo_zero: assert property (!ctl_q[BIT_ALIGN] |-> res_lo[3:0] == 4'h0)
    else $error("unused low bits nonzero");
  a_float_chan: assert property (ctl_q[3] |-> ext_channel_route_o == '0)
    else $error("channel routed for missing code");
  a_busy_ro: assert property (wr && wb_adr_i == OFS_CONTROL_MAIN && !start_fall
                              && !conv_done_i |=> busy_q == $past(busy_q))
    else $error("write changed busy");
  a_ref_sel: assert property (ref_from_supply_o == (sel_q[4:3] == 2'b01))
    else $error("reference decode wrong");

  // ---------------------------------------------------------------
  // bus handshake checks
  // ---------------------------------------------------------------
  sequence s_req_mapped;
    acc && hit;
  endsequence

  sequence s_req_unmapped;
    acc && !hit;
  endsequence

  // ack and err are single pulses, so a master never sees one twice
  a_ack_pulse: assert property (s_req_mapped |=> wb_ack_o && !wb_err_o ##1 !wb_ack_o)
    else $error("ack not a single pulse");
  a_err_pulse: assert property (s_req_unmapped |=> wb_err_o && !wb_ack_o ##1 !wb_err_o)
    else $error("err not a single pulse");

  // ---------------------------------------------------------------
  // conversion checks
  // ---------------------------------------------------------------
  sequence s_done_seen;
    done_ev && !start_fall;
  endsequence

  // core start only ever follows a start bit falling write
  a_start_cause: assert property ($rose(conv_start_o) |-> $past(start_fall))
    else $error("core start without start write");
  a_busy_cause: assert property ($rose(busy_q) |-> $past(start_fall))
    else $error("busy set without start");
  a_busy_end: assert property ($fell(busy_q) |-> $past(conv_done_i))
    else $error("busy cleared without done");
  a_result_cause: assert property ($changed(result_q) |-> $past(done_ev))
    else $error("result changed without completion");
  a_hold_off: assert property (!conv_power_o && !done_ev |=> $stable(result_q))
    else $error("result changed while powered down");
  a_done_clears: assert property (s_done_seen |=> !busy_q && irq_stat_q[IRQ_DONE])
    else $error("completion not flagged");
  a_irq_raise: assert property (s_done_seen ##0 irq_mask_q[0] && !wr |=> irq_o)
    else $error("unmasked completion gave no interrupt");
  a_mask_gate: assert property (!irq_mask_q[0] |-> !irq_o)
    else $error("masked flag raised the interrupt");

  // ---------------------------------------------------------------
  // result format checks
  // ---------------------------------------------------------------
  // a read that no completion overlaps; the byte lands one edge later
  sequence s_read_high;
    acc && !wb_we_i && wb_adr_i == OFS_RESULT_HIGH && !done_ev ##1 1'b1;
  endsequence

  sequence s_read_low;
    acc && !wb_we_i && wb_adr_i == OFS_RESULT_LOW && !done_ev ##1 1'b1;
  endsequence

  a_high_fmt0: assert property (s_read_high ##0 !ctl_q[BIT_ALIGN] |->
                                wb_dat_o == {24'h00_0000, result_q[11:4]})
    else $error("high byte wrong with align 0");
  a_low_fmt0: assert property (s_read_low ##0 !ctl_q[BIT_ALIGN] |->
                               wb_dat_o == {24'h00_0000, result_q[3:0], 4'h0})
    else $error("low byte wrong with align 0");
  a_high_fmt1: assert property (s_read_high ##0 ctl_q[BIT_ALIGN] |->
                                wb_dat_o == {28'h000_0000, result_q[11:8]})
    else $error("high byte wrong with align 1");
  a_low_fmt1: assert property (s_read_low ##0 ctl_q[BIT_ALIGN] |->
                               wb_dat_o == {24'h00_0000, result_q[7:0]})
    else $error("low byte wrong with align 1");

  // ---------------------------------------------------------------
  // register and routing checks
  // ---------------------------------------------------------------
  sequence s_read_main;
    acc && !wb_we_i && wb_adr_i == OFS_CONTROL_MAIN;
  endsequence

  a_busy_read: assert property (s_read_main |=> wb_dat_o[BIT_BUSY] == $past(busy_q))
    else $error("busy readback wrong");
  a_tick_off: assert property (!conv_power_o |-> !conv_clk_en_o)
    else $error("conversion clock runs while off");
  a_tick_full: assert property (conv_power_o && sel_q[POS_DIV +: 3] == 3'h0
                                |-> conv_clk_en_o)
    else $error("undivided clock missed a tick");
  a_chan_onehot: assert property (!ctl_q[3] |-> $onehot(ext_channel_route_o))
    else $error("existing channel not routed");
  a_src_ext: assert property (sel_q[7:5] == 3'h0 || (sel_q[7] && sel_q[6:5] != 2'b00)
                              |-> source_route_o == ADCC_SRC_EXT)
    else $error("external source not routed");
  a_pull_off: assert property (pull_high_allow_o == ~analog_pin_bits_o)
    else $error("pull-high left on an analog pin");

endmodule

// ==== bench/adcc_core_model.sv ====
// Purpose: behavioural analog core behind the converter control block
// Assumes: one conversion takes four conversion clock ticks
// Notes: result lines show the inverse of the last result outside done
module adcc_core_model #(
  parameter logic [11:0] VALUE = 12'hA5C
) (
  input wire logic mclk_i, // system clock
  input wire logic srst_i, // sync reset
  input wire logic start_i, // start pulse
  input wire logic power_i, // core powered
  input wire logic tick_i, // conversion clock tick
  output logic done_o, // done pulse
  output logic [11:0] data_o // result
);
  int left;
  logic [11:0] last;

  always_ff @(posedge mclk_i) begin
    done_o <= 1'b0;
    // no hold after done, so a late sample cannot pass by luck
    data_o <= ~last;
    if (srst_i) begin
      left <= 0;
      last <= 12'h000;
    end else if (start_i && power_i) begin
      left <= 4;
    end else if (left > 0 && tick_i) begin
      left <= left - 1;
      if (left == 1) begin
        done_o <= 1'b1;
        data_o <= VALUE;
        last <= VALUE;
      end
    end
  end
endmodule

// ==== bench/adcc_top_tb_top.sv ====
// Purpose: register level test of the converter control block
// Assumes: one wait-free wishbone slave, lane 0 carries the byte
// Notes: conversions run with a slow divider so busy can be seen
module adcc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import adcc_pkg::*;
  logic mclk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat, q;
  logic ack, err, irq, start, power, ref_sup, tick, done, last_err;
  logic [1:0] src;
  logic [7:0] route, pins, pulls;
  logic [11:0] cdata;
  int fail_count = 0;
  int comparisons = 0;
  int n;

  initial forever #20 mclk = ~mclk;

  adcc_top dut (.mclk_i(mclk), .srst_i(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .irq_o(irq), .conv_start_o(start),
    .conv_power_o(power), .ext_channel_route_o(route), .source_route_o(src),
    .ref_from_supply_o(ref_sup), .conv_clk_en_o(tick), .analog_pin_bits_o(pins),
    .pull_high_allow_o(pulls), .conv_done_i(done), .conv_data_i(cdata));

  adcc_core_model core (.mclk_i(mclk), .srst_i(srst), .start_i(start),
    .power_i(power), .tick_i(tick), .done_o(done), .data_o(cdata));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task close_out;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (ack !== 1'b1 && err !== 1'b1 && k < 20);
    q = rdat;
    last_err = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1 && err !== 1'b1) begin
      fail_count++;
      close_out();
    end
  endtask

  // bounded count of cycles up to the next divider tick
  task wait_tick(output int c);
    c = 0;
    do begin
      @(posedge mclk);
      c++;
    end while (tick !== 1'b1 && c < 300);
    if (c >= 300) begin
      fail_count++;
      close_out();
    end
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 2; i < 5; i++) begin
      wb(1'b0, 8'(i * 4), 8'h00);
      check(q, 32'h0000_0000);
    end
    wb(1'b1, OFS_CONTROL_SELECT, 8'h03);
    wb(1'b1, OFS_CONTROL_MAIN, 8'h30);
    check(power, 1'b1);
    wb(1'b1, OFS_CONTROL_MAIN, 8'hB0);
    wb(1'b1, OFS_CONTROL_MAIN, 8'h30);
    wb(1'b0, OFS_CONTROL_MAIN, 8'h00);
    check(q, 32'h0000_0070);
    for (int k = 0; k < 100 && q[6] !== 1'b0; k++) wb(1'b0, OFS_CONTROL_MAIN, 8'h00);
    check(q, 32'h0000_0030);
    wb(1'b0, OFS_RESULT_HIGH, 8'h00);
    check(q, 32'h0000_000A);
    wb(1'b0, OFS_RESULT_LOW, 8'h00);
    check(q, 32'h0000_005C);
    wb(1'b1, OFS_CONTROL_MAIN, 8'h20);
    wb(1'b0, OFS_RESULT_HIGH, 8'h00);
    check(q, 32'h0000_00A5);
    wb(1'b0, OFS_RESULT_LOW, 8'h00);
    check(q, 32'h0000_00C0);
    wb(1'b0, OFS_IRQ_STATUS, 8'h00);
    check(q, 32'h0000_0001);
    check(irq, 1'b0);
    wb(1'b1, OFS_IRQ_MASK, 8'h01);
    check(irq, 1'b1);
    wb(1'b1, OFS_IRQ_STATUS, 8'h01);
    check(irq, 1'b0);
    wb(1'b1, OFS_CONTROL_MAIN, 8'h60);
    wb(1'b0, OFS_CONTROL_MAIN, 8'h00);
    check(q, 32'h0000_0020);
    wb(1'b1, OFS_CONTROL_MAIN, 8'h00);
    check(power, 1'b0);
    wb(1'b0, OFS_RESULT_HIGH, 8'h00);
    check(q, 32'h0000_00A5);
    for (int i = 0; i < 16; i++) begin
      wb(1'b1, OFS_CONTROL_MAIN, 8'(i));
      check(route, (i < 8) ? (32'h0000_0001 << i) : 32'h0000_0000);
    end
    // channel left at a missing code while all eight source codes are stepped
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, OFS_CONTROL_SELECT, 8'(i * 32 + (i % 4) * 8));
      check(src, (i == 1) ? 2'h1 : (i >= 2 && i <= 4) ? 2'h2 : 2'h0);
      check(ref_sup, (i % 4) == 1);
    end
    wb(1'b1, OFS_CONTROL_MAIN, 8'h28);
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, OFS_CONTROL_SELECT, 8'(c));
      wait_tick(n);
      wait_tick(n);
      check(n, 1 << c);
    end
    wb(1'b1, OFS_PIN_ENABLE, 8'hA5);
    check(pins, 8'hA5);
    check(pulls, 8'h5A);
    wb(1'b0, 8'h1C, 8'h00);
    check(last_err, 1'b1);
    close_out();
  end
endmodule
